// ==== core/ctl_port_pkg.sv ====
// constants and types shared by both ends of the filter serial control port
package ctl_port_pkg;

    // ----------------------------------------------------------------
    // frame layout
    // ----------------------------------------------------------------
    localparam int         DATA_W     = 24;
    localparam int         ADDR_W     = 5;
    localparam int         CHIP_W     = 3;
    localparam int         FRAME_W    = 32;
    localparam int         NUM_REGS   = 32;
    localparam int         DATA_LSB   = 8;
    localparam int         ADDR_LSB   = 3;
    localparam int         CHIP_LSB   = 0;
    localparam logic [2:0] CHIP_ADDR  = 3'h5;
    localparam logic [4:0] PTR_REG    = 5'h00;
    localparam logic [5:0] BIT_FIRST  = 6'h00;
    localparam logic [5:0] BIT_LAST   = 6'h1f;
    localparam logic [5:0] BIT_FULL   = 6'h20;

    // ----------------------------------------------------------------
    // register values
    // ----------------------------------------------------------------
    localparam logic [23:0] REG_DEFAULT    = 24'h00_0000;
    localparam logic [23:0] SOFT_RESET_ARM = 24'h00_0020;
    localparam logic [23:0] SOFT_RESET_GO  = 24'h00_0000;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int         CLK_FREQ_MHZ   = 100;
    localparam int         POR_TIME_US    = 250;
    localparam int         POR_CYCLES_DEF = POR_TIME_US * CLK_FREQ_MHZ;
    localparam logic [3:0] HOST_HALF      = 4'h5;
    localparam logic [3:0] HOST_GAP       = 4'h8;

    typedef logic [DATA_W-1:0]  data_t;
    typedef logic [FRAME_W-1:0] frame_t;
    typedef enum logic [1:0] {HOST_IDLE, HOST_LOW, HOST_HIGH, HOST_GAP_ST} host_state_t;

endpackage : ctl_port_pkg

// ==== core/ctl_port_if.sv ====
// link wires between the host end and the device end of the control port
`timescale 1ns/10ps
`default_nettype none
interface ctl_port_if;
    logic select_low;
    logic sck;
    logic sdi;
    logic sdo;
    logic sdo_oe;
    logic sdo_line;

    // released line is pulled high
    assign sdo_line = sdo_oe ? sdo : 1'h1;

    modport dev  (input select_low, input sck, input sdi, output sdo, output sdo_oe);
    modport host (output select_low, output sck, output sdi, input sdo_line);
endinterface : ctl_port_if
`default_nettype wire

// ==== core/ctl_port_dev.sv ====
// device end of the filter serial control port: frame shifter and register file
`timescale 1ns/10ps
`default_nettype none
module ctl_port_dev #(
    parameter int unsigned POR_CYCLES = ctl_port_pkg::POR_CYCLES_DEF
) (
    input  wire logic                                          CLK,
    input  wire logic                                          RST_B,
    ctl_port_if.dev                                            LINK,
    output var  logic                                          READY,
    output var  logic [ctl_port_pkg::NUM_REGS*ctl_port_pkg::DATA_W-1:0] REGS
);
    import ctl_port_pkg::*;

    // ----------------------------------------------------------------
    // link domain: shift in, shift out
    // ----------------------------------------------------------------
    logic [5:0]         cnt_r;
    logic [5:0]         cnt_nxt;
    frame_t             in_r;
    frame_t             in_nxt;
    logic [FRAME_W-2:0] out_r;
    logic [FRAME_W-2:0] out_nxt;
    logic               sdo_r;
    logic               sdo_nxt;
    frame_t             cap_r;
    frame_t             cap_nxt;
    logic               tgl_r;
    logic               tgl_nxt;
    frame_t             rd_word_r;
    frame_t             rd_word_nxt;

    always_comb begin
        in_nxt  = {in_r[FRAME_W-2:0], LINK.sdi};
        cnt_nxt = (cnt_r == BIT_FULL) ? cnt_r : cnt_r + 6'h01;
        if (cnt_r == BIT_FIRST) begin
            // word is quasi-static: it only moves while select is high
            sdo_nxt = rd_word_r[FRAME_W-1];
            out_nxt = rd_word_r[FRAME_W-2:0];
        end else begin
            sdo_nxt = out_r[FRAME_W-2];
            out_nxt = {out_r[FRAME_W-3:0], 1'h0};
        end
    end

    // select high holds the frame logic idle; the clock may stop there
    always_ff @(posedge LINK.sck or posedge LINK.select_low) begin
        if (LINK.select_low) begin
            cnt_r <= BIT_FIRST;
            in_r  <= '0;
            out_r <= '0;
            sdo_r <= 1'h0;
        end else begin
            cnt_r <= cnt_nxt;
            in_r  <= in_nxt;
            out_r <= out_nxt;
            sdo_r <= sdo_nxt;
        end
    end

    always_comb begin
        cap_nxt = cap_r;
        tgl_nxt = tgl_r;
        if (cnt_r == BIT_LAST) begin
            // only a frame that reached its 32nd edge is handed over
            cap_nxt = in_nxt;
            tgl_nxt = ~tgl_r;
        end
    end

    always_ff @(posedge LINK.sck or negedge RST_B) begin
        if (!RST_B) begin
            cap_r <= '0;
            tgl_r <= 1'h0;
        end else begin
            cap_r <= cap_nxt;
            tgl_r <= tgl_nxt;
        end
    end

    // ----------------------------------------------------------------
    // crossing into the system clock
    // ----------------------------------------------------------------
    logic sel_s1_r;
    logic sel_s2_r;
    logic tgl_s1_r;
    logic tgl_s2_r;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            sel_s1_r <= 1'h1;
            sel_s2_r <= 1'h1;
            tgl_s1_r <= 1'h0;
            tgl_s2_r <= 1'h0;
        end else begin
            sel_s1_r <= LINK.select_low;
            sel_s2_r <= sel_s1_r;
            tgl_s1_r <= tgl_r;
            tgl_s2_r <= tgl_s1_r;
        end
    end

    // ----------------------------------------------------------------
    // system domain: commit, soft reset, power-on load
    // ----------------------------------------------------------------
    data_t        regs_r   [NUM_REGS];
    data_t        regs_nxt [NUM_REGS];
    logic         seen_r;
    logic         seen_nxt;
    logic         oe_r;
    logic         oe_nxt;
    logic         armed_r;
    logic         armed_nxt;
    logic         ready_r;
    logic         ready_nxt;
    logic [31:0]  por_r;
    logic [31:0]  por_nxt;
    data_t        c_data;
    logic [4:0]   c_addr;
    logic [2:0]   c_chip;
    logic [4:0]   ptr;

    always_comb begin
        regs_nxt  = regs_r;
        seen_nxt  = seen_r;
        oe_nxt    = oe_r;
        armed_nxt = armed_r;
        ready_nxt = ready_r;
        por_nxt   = por_r;
        c_data    = cap_r[DATA_LSB +: DATA_W];
        c_addr    = cap_r[ADDR_LSB +: ADDR_W];
        c_chip    = cap_r[CHIP_LSB +: CHIP_W];
        if (!ready_r) begin
            por_nxt = por_r + 32'h0000_0001;
            if (por_r == 32'(POR_CYCLES - 1)) begin
                ready_nxt = 1'h1;
                for (int i = 0; i < NUM_REGS; i++) begin
                    regs_nxt[i] = REG_DEFAULT;
                end
            end
        end
        // cap_r is stable here: it moved on the same link edge as the toggle that is seen now
        if (sel_s2_r && (tgl_s2_r != seen_r)) begin
            seen_nxt = tgl_s2_r;
            if (ready_r && (c_chip == CHIP_ADDR)) begin
                oe_nxt           = 1'h1;
                regs_nxt[c_addr] = c_data;
                if (c_addr == PTR_REG) begin
                    if (armed_r && (c_data == SOFT_RESET_GO)) begin
                        armed_nxt = 1'h0;
                        for (int i = 0; i < NUM_REGS; i++) begin
                            regs_nxt[i] = REG_DEFAULT;
                        end
                    end else begin
                        armed_nxt = (c_data == SOFT_RESET_ARM);
                    end
                end else begin
                    armed_nxt = 1'h0;
                end
            end else if (ready_r) begin
                oe_nxt = 1'h0;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_r[i] <= REG_DEFAULT;
            end
            seen_r  <= 1'h0;
            oe_r    <= 1'h0;
            armed_r <= 1'h0;
            ready_r <= 1'h0;
            por_r   <= 32'h0000_0000;
        end else begin
            regs_r  <= regs_nxt;
            seen_r  <= seen_nxt;
            oe_r    <= oe_nxt;
            armed_r <= armed_nxt;
            ready_r <= ready_nxt;
            por_r   <= por_nxt;
        end
    end

    // ----------------------------------------------------------------
    // read-back word from the pointer register
    // ----------------------------------------------------------------
    always_comb begin
        ptr         = regs_r[PTR_REG][ADDR_W-1:0];
        rd_word_nxt = {regs_r[ptr], ptr, CHIP_ADDR};
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rd_word_r <= '0;
        end else begin
            rd_word_r <= rd_word_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign LINK.sdo    = sdo_r;
    assign LINK.sdo_oe = oe_r;
    assign READY       = ready_r;

    for (genvar g = 0; g < NUM_REGS; g++) begin : g_regs
        assign REGS[g*DATA_W +: DATA_W] = regs_r[g];
    end

endmodule : ctl_port_dev
`default_nettype wire

// ==== core/ctl_port_host.sv ====
// host end of the filter serial control port: clock divider and frame sequencer
`timescale 1ns/10ps
`default_nettype none
module ctl_port_host (
    input  wire logic                        CLK,
    input  wire logic                        RST_B,
    ctl_port_if.host                         LINK,
    input  wire logic                        START,
    input  wire logic [ctl_port_pkg::DATA_W-1:0] DATA,
    input  wire logic [ctl_port_pkg::ADDR_W-1:0] ADDR,
    input  wire logic [ctl_port_pkg::CHIP_W-1:0] CHIP,
    output var  logic                        BUSY,
    output var  logic                        DONE,
    output var  logic [ctl_port_pkg::FRAME_W-1:0] RD_WORD
);
    import ctl_port_pkg::*;

    // ----------------------------------------------------------------
    // sampling of the returned line
    // ----------------------------------------------------------------
    logic sdo_s1_r;
    logic sdo_s2_r;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            sdo_s1_r <= 1'h1;
            sdo_s2_r <= 1'h1;
        end else begin
            sdo_s1_r <= LINK.sdo_line;
            sdo_s2_r <= sdo_s1_r;
        end
    end

    // ----------------------------------------------------------------
    // frame sequencer
    // ----------------------------------------------------------------
    host_state_t state_r, state_nxt;
    logic [3:0]  ph_r, ph_nxt;
    logic [5:0]  bits_r, bits_nxt;
    frame_t      tx_r, tx_nxt;
    frame_t      rx_r, rx_nxt;
    frame_t      rd_r, rd_nxt;
    logic        sck_r, sck_nxt;
    logic        sel_r, sel_nxt;
    logic        sdi_r, sdi_nxt;
    logic        busy_r, busy_nxt;
    logic        done_r, done_nxt;
    frame_t      word;

    always_comb begin
        state_nxt = state_r;
        ph_nxt    = ph_r + 4'h1;
        bits_nxt  = bits_r;
        tx_nxt    = tx_r;
        rx_nxt    = rx_r;
        rd_nxt    = rd_r;
        sck_nxt   = sck_r;
        sel_nxt   = sel_r;
        sdi_nxt   = sdi_r;
        busy_nxt  = busy_r;
        done_nxt  = 1'h0;
        // reads are two frames chosen by the user: pointer write, then retrieval
        word      = {DATA, ADDR, CHIP};
        case (state_r)
            HOST_IDLE: begin
                ph_nxt = 4'h0;
                if (START) begin
                    // one select line only; a second device needs its own
                    sel_nxt   = 1'h0;
                    sdi_nxt   = word[FRAME_W-1];
                    tx_nxt    = {word[FRAME_W-2:0], 1'h0};
                    bits_nxt  = BIT_FIRST;
                    busy_nxt  = 1'h1;
                    state_nxt = HOST_LOW;
                end
            end
            HOST_LOW: begin
                if (ph_r == HOST_HALF - 4'h1) begin
                    ph_nxt    = 4'h0;
                    sck_nxt   = 1'h1;
                    state_nxt = HOST_HIGH;
                end
            end
            HOST_HIGH: begin
                if (ph_r == HOST_HALF - 4'h1) begin
                    ph_nxt   = 4'h0;
                    sck_nxt  = 1'h0;
                    rx_nxt   = {rx_r[FRAME_W-2:0], sdo_s2_r};
                    bits_nxt = bits_r + 6'h01;
                    if (bits_r == BIT_LAST) begin
                        sel_nxt   = 1'h1;
                        state_nxt = HOST_GAP_ST;
                    end else begin
                        sdi_nxt   = tx_r[FRAME_W-1];
                        tx_nxt    = {tx_r[FRAME_W-2:0], 1'h0};
                        state_nxt = HOST_LOW;
                    end
                end
            end
            HOST_GAP_ST: begin
                // long enough for the device to commit and reload its word
                if (ph_r == HOST_GAP - 4'h1) begin
                    ph_nxt    = 4'h0;
                    busy_nxt  = 1'h0;
                    done_nxt  = 1'h1;
                    rd_nxt    = rx_r;
                    state_nxt = HOST_IDLE;
                end
            end
            default: begin
                state_nxt = HOST_IDLE;
                sel_nxt   = 1'h1;
                sck_nxt   = 1'h0;
                busy_nxt  = 1'h0;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_r <= HOST_IDLE;
            ph_r    <= 4'h0;
            bits_r  <= BIT_FIRST;
            tx_r    <= '0;
            rx_r    <= '0;
            rd_r    <= '0;
            sck_r   <= 1'h0;
            sel_r   <= 1'h1;
            sdi_r   <= 1'h0;
            busy_r  <= 1'h0;
            done_r  <= 1'h0;
        end else begin
            state_r <= state_nxt;
            ph_r    <= ph_nxt;
            bits_r  <= bits_nxt;
            tx_r    <= tx_nxt;
            rx_r    <= rx_nxt;
            rd_r    <= rd_nxt;
            sck_r   <= sck_nxt;
            sel_r   <= sel_nxt;
            sdi_r   <= sdi_nxt;
            busy_r  <= busy_nxt;
            done_r  <= done_nxt;
        end
    end

    assign LINK.sck        = sck_r;
    assign LINK.select_low = sel_r;
    assign LINK.sdi        = sdi_r;
    assign BUSY            = busy_r;
    assign DONE            = done_r;
    assign RD_WORD         = rd_r;

endmodule : ctl_port_host
`default_nettype wire

// ==== core/README_unused.sv ====
// reserved source slot: holds no logic
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ==== sim/ctl_port_chk.sv ====
// checker of the link between the host end and the device end
`timescale 1ns/10ps
`default_nettype none
module ctl_port_chk (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic select_low,
    input wire logic sck,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe,
    input wire logic sdo_line
);
    logic [5:0] rise_cnt;
    logic       sck_q;
    logic [2:0] chip_r;

    // ----------------------------------------------------------------
    // helper: rising link edges seen in the current frame
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rise_cnt <= 6'h00;
            sck_q    <= 1'h0;
            chip_r   <= 3'h0;
        end else begin
            sck_q <= sck;
            if (select_low) begin
                rise_cnt <= 6'h00;
            end else if (sck && !sck_q) begin
                rise_cnt <= rise_cnt + 6'h01;
                // last three bits of a frame stay here through the gap
                chip_r   <= {chip_r[1:0], sdi};
            end
        end
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    frame_len_a: assert property ($rose(select_low) |-> rise_cnt == 6'h20)
        else $error("frame closed after a wrong edge count");
    gap_hold_a: assert property ($rose(select_low) |=> select_low [*6])
        else $error("select gap too short");
    idle_clock_a: assert property ($rose(sck) |-> !select_low)
        else $error("link clock rose outside a frame");
    select_rise_a: assert property ($rose(select_low) |-> !sck && $past(sck))
        else $error("select did not rise with the last falling edge");
    first_edge_a: assert property ($fell(select_low) |-> ##[1:12] $rose(sck))
        else $error("no first rising edge after select");
    edge_space_a: assert property ($rose(sck) |=> (!$rose(sck)) [*8])
        else $error("link clock edges too close");
    sdi_hold_a: assert property (sck && $past(sck) |-> $stable(sdi))
        else $error("serial input moved while clock high");
    sdo_launch_a: assert property (!select_low && $past(!select_low) && $changed(sdo) |-> $rose(sck))
        else $error("serial output moved off a rising edge");
    oe_frame_a: assert property ($changed(sdo_oe) |-> select_low && $past(select_low))
        else $error("output enable changed inside a frame");
    oe_off_a: assert property (!sdo_oe |-> sdo_line)
        else $error("released output line not high");
    oe_on_a: assert property ($rose(sdo_oe) |-> chip_r == 3'h5)
        else $error("output enabled after a foreign frame");
    oe_release_a: assert property ($fell(sdo_oe) |-> chip_r != 3'h5)
        else $error("output released after an own frame");
endmodule : ctl_port_chk
`default_nettype wire

// ==== sim/testbench.sv ====
// self-checking bench: host end and device end joined, plus a bench-driven second link
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import ctl_port_pkg::*;

    logic         clk;
    logic         rst_b;
    logic         start;
    data_t        data;
    logic [4:0]   addr;
    logic [2:0]   chip;
    logic         busy;
    logic         done;
    frame_t       rd_word;
    logic         ready;
    logic         ready_b;
    logic [767:0] regs;
    logic [767:0] regs_b;
    frame_t       mon_word;
    int           bad_count;
    int           total_checks;
    int           cycles;

    ctl_port_if link_a();
    ctl_port_if link_b();

    ctl_port_host ctl_port_host_i (.CLK(clk), .RST_B(rst_b), .LINK(link_a), .START(start), .DATA(data),
        .ADDR(addr), .CHIP(chip), .BUSY(busy), .DONE(done), .RD_WORD(rd_word));
    ctl_port_dev #(.POR_CYCLES(20)) ctl_port_dev_i (.CLK(clk), .RST_B(rst_b), .LINK(link_a),
        .READY(ready), .REGS(regs));
    // second device faces the bench, which breaks framing on purpose
    ctl_port_dev #(.POR_CYCLES(20)) ctl_port_dev_i2 (.CLK(clk), .RST_B(rst_b), .LINK(link_b),
        .READY(ready_b), .REGS(regs_b));
    ctl_port_chk ctl_port_chk_i (.CLK(clk), .RST_B(rst_b), .select_low(link_a.select_low),
        .sck(link_a.sck), .sdi(link_a.sdi), .sdo(link_a.sdo), .sdo_oe(link_a.sdo_oe),
        .sdo_line(link_a.sdo_line));

    // ----------------------------------------------------------------
    // clock, timeout and wire monitor
    // ----------------------------------------------------------------
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            complete_run();
        end
    end

    always @(negedge link_a.select_low) mon_word = 32'h0000_0000;
    always @(posedge link_a.sck) begin
        if (!link_a.select_low) begin
            mon_word = {mon_word[30:0], link_a.sdi};
        end
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    function automatic data_t reg_of(input logic [767:0] r, input int n);
        return r[n*24 +: 24];
    endfunction : reg_of

    task automatic frame(input data_t d, input logic [4:0] a, input logic [2:0] c);
        int n;
        n = 0;
        @(posedge clk);
        #1 start = 1'h1;
        data = d;
        addr = a;
        chip = c;
        @(posedge clk);
        #1 start = 1'h0;
        check("busy", {31'h0, busy}, 32'h0000_0001);
        do begin
            @(posedge clk);
            #1 n++;
        end while (done !== 1'h1 && n < 400);
        check("done", {31'h0, done}, 32'h0000_0001);
        check("idle", {31'h0, busy}, 32'h0000_0000);
        repeat (3) @(posedge clk);
    endtask : frame

    // bench plays host on the second link; a 15 ns clock only inside frames
    task automatic raw_frame(input frame_t w, input int nbits);
        #1 link_b.sdi = w[31];
        link_b.select_low = 1'h0;
        for (int i = 0; i < nbits; i++) begin
            #7.5 link_b.sck = 1'h1;
            #7.5 link_b.sck = 1'h0;
            if (i < 31) link_b.sdi = w[30-i];
        end
        #7.5 link_b.select_low = 1'h1;
        link_b.sdi = ~link_b.sdi;
        repeat (20) @(posedge clk);
    endtask : raw_frame

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_b = 1'h0;
        start = 1'h0;
        data = 24'h00_0000;
        addr = 5'h00;
        chip = 3'h0;
        link_b.select_low = 1'h1;
        link_b.sck = 1'h0;
        link_b.sdi = 1'h0;
        bad_count = 0;
        total_checks = 0;
        cycles = 0;
        repeat (5) @(posedge clk);
        #1 rst_b = 1'h1;
        repeat (10) @(posedge clk);
        check("ready early", {31'h0, ready}, 32'h0000_0000);
        repeat (15) @(posedge clk);
        check("ready late", {30'h0, ready, ready_b}, 32'h0000_0003);
        frame(24'h00_1234, 5'h04, 3'h2);
        check("released read", rd_word, 32'hFFFF_FFFF);
        check("foreign write", reg_of(regs, 4), 32'h0000_0000);
        frame(24'hA5_5A3C, 5'h03, CHIP_ADDR);
        check("write reg3", reg_of(regs, 3), 32'h00A5_5A3C);
        check("wire word", mon_word, {24'hA5_5A3C, 5'h03, 3'h5});
        frame(24'h00_0003, PTR_REG, CHIP_ADDR);
        check("driven read", rd_word, {24'h00_0000, 5'h00, 3'h5});
        frame(24'h12_3456, 5'h06, CHIP_ADDR);
        check("retrieved word", rd_word, {24'hA5_5A3C, 5'h03, 3'h5});
        check("retrieval write", reg_of(regs, 6), 32'h0012_3456);
        // pointer-addressed retrieval reads without touching the configuration
        frame(24'h00_0006, PTR_REG, CHIP_ADDR);
        check("pointer read", rd_word, {24'hA5_5A3C, 5'h03, 3'h5});
        check("pointer kept", reg_of(regs, 3), 32'h00A5_5A3C);
        frame(24'h00_0000, 5'h06, 3'h4);
        check("held output", rd_word, {24'h12_3456, 5'h06, 3'h5});
        check("reg6 kept", reg_of(regs, 6), 32'h0012_3456);
        frame(24'h00_0000, 5'h06, 3'h4);
        check("output released", rd_word, 32'hFFFF_FFFF);
        // every chip code: only 101 may land
        for (int c = 0; c < 8; c++) begin
            frame(24'h00_0100 + 24'(c), 5'h07, 3'(c));
            check("chip code", reg_of(regs, 7), (c < 5) ? 32'h0000_0000 : 32'h0000_0105);
        end
        frame(SOFT_RESET_ARM, PTR_REG, CHIP_ADDR);
        check("arm word", reg_of(regs, 0), 32'h0000_0020);
        frame(SOFT_RESET_GO, PTR_REG, CHIP_ADDR);
        for (int n = 0; n < 32; n++) check("soft reset", reg_of(regs, n), 32'h0000_0000);
        raw_frame({24'h00_0ABC, 5'h02, 3'h5}, 32);
        check("bench frame", reg_of(regs_b, 2), 32'h0000_0ABC);
        raw_frame({24'h00_0FFF, 5'h02, 3'h5}, 31);
        check("short frame", reg_of(regs_b, 2), 32'h0000_0ABC);
        complete_run();
    end
endmodule : testbench
`default_nettype wire
